/* verilog/mic_tx_timing.v */
// Transmit gap, deferral, collision window and retry control with AXI regs
`timescale 1ns/100ps
`include "mic_defines.vh"
module mic_tx_timing (
   input wire ref_clk,
   input wire sys_rst,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire pkt_pending,
   input wire tx_done,
   input wire crs_pin,
   input wire col_pin,
   output reg tx_go,
   output reg tx_abort,
   output reg tx_retry,
   output reg irq
);
   localparam ST_GAP = 4'b0001;
   localparam ST_READY = 4'b0010;
   localparam ST_XMIT = 4'b0100;
   localparam ST_BACK = 4'b1000;

   function [31:0] wmerge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer i;
      begin
         wmerge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i])
               wmerge[i*8 +: 8] = data[i*8 +: 8];
         end
      end
   endfunction

   function mapped;
      input [31:0] a;
      begin
         mapped = (a == `MIC_ADDR_B2B) || (a == `MIC_ADDR_NB2B) ||
            (a == `MIC_ADDR_CWR) || (a == `MIC_ADDR_CTRL) ||
            (a == `MIC_ADDR_STAT) || (a == `MIC_ADDR_MASK) ||
            (a == `MIC_ADDR_STATE);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Registers
   reg [31:0] b2b_r, nb2b_r, cwr_r, ctrl_r;
   reg [`MIC_EV_W-1:0] stat_r, mask_r;
   reg aw_hold_r, w_hold_r;
   reg [31:0] aw_addr_r, w_data_r;
   reg [3:0] w_strb_r;
   wire aw_take, w_take, do_write, ar_take, aw_hold_nxt, w_hold_nxt;
   reg [31:0] rd_mux;
   reg [3:0] state_r, att_r;
   reg [`MIC_EV_W-1:0] ev;

   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take = s_axi_wvalid & s_axi_wready;
   // Write lands one cycle after both halves are held
   assign do_write = aw_hold_r & w_hold_r & ~s_axi_bvalid;
   assign aw_hold_nxt = (aw_hold_r | aw_take) & ~do_write;
   assign w_hold_nxt = (w_hold_r | w_take) & ~do_write;
   assign ar_take = s_axi_arvalid & s_axi_arready;
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= 32'h00000000;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MIC_RESP_OK;
         b2b_r <= {25'h0000000, `MIC_B2B_RST};
         nb2b_r <= {17'h00000, `MIC_SLOT_WINDOW_LEN_RST, 1'b0, `MIC_NB2B_RST};
         cwr_r <= {18'h00000, `MIC_SLOT_RST, 4'h0, `MIC_RETRY_RST};
         ctrl_r <= 32'h00000000;
         stat_r <= {`MIC_EV_W{1'b0}};
         mask_r <= {`MIC_EV_W{1'b0}};
      end else begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         s_axi_awready <= ~aw_hold_nxt;
         s_axi_wready <= ~w_hold_nxt;
         if (aw_take)
            aw_addr_r <= s_axi_awaddr;
         if (w_take) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr_r) ? `MIC_RESP_OK : `MIC_RESP_ERR;
         end
         // Reserved bits stay zero whatever is written
         if (do_write && aw_addr_r == `MIC_ADDR_B2B)
            b2b_r <= wmerge(b2b_r, w_data_r, w_strb_r) & 32'h0000007f;
         if (do_write && aw_addr_r == `MIC_ADDR_NB2B)
            nb2b_r <= wmerge(nb2b_r, w_data_r, w_strb_r) & 32'h00007f7f;
         if (do_write && aw_addr_r == `MIC_ADDR_CWR)
            cwr_r <= wmerge(cwr_r, w_data_r, w_strb_r) & 32'h00003f0f;
         if (do_write && aw_addr_r == `MIC_ADDR_CTRL)
            ctrl_r <= wmerge(ctrl_r, w_data_r, w_strb_r) & 32'h00001001;
         if (do_write && aw_addr_r == `MIC_ADDR_MASK && w_strb_r[0])
            mask_r <= w_data_r[`MIC_EV_W-1:0];
         // A new event beats a same-cycle write-one clear
         if (do_write && aw_addr_r == `MIC_ADDR_STAT && w_strb_r[0]) begin
            stat_r <= (stat_r & ~w_data_r[`MIC_EV_W-1:0]) | ev;
         end else begin
            stat_r <= stat_r | ev;
         end
      end
   end

   always @* begin
      case (s_axi_araddr)
         `MIC_ADDR_B2B: rd_mux = b2b_r;
         `MIC_ADDR_NB2B: rd_mux = nb2b_r;
         `MIC_ADDR_CWR: rd_mux = cwr_r;
         `MIC_ADDR_CTRL: rd_mux = ctrl_r;
         `MIC_ADDR_STAT: rd_mux = {28'h0000000, stat_r};
         `MIC_ADDR_MASK: rd_mux = {28'h0000000, mask_r};
         `MIC_ADDR_STATE: rd_mux = {24'h000000, att_r, state_r};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `MIC_RESP_OK;
         irq <= 1'b0;
      end else begin
         irq <= |((stat_r | ev) & mask_r);
         if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= mapped(s_axi_araddr) ? `MIC_RESP_OK
               : `MIC_RESP_ERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (~s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers and nibble-rate enable
   reg [2:0] crs_s_r, col_s_r;
   reg crs_f_r, col_f_r;
   reg [3:0] div_r;
   reg nib_en_r;

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         crs_s_r <= 3'h0;
         col_s_r <= 3'h0;
         crs_f_r <= 1'b0;
         col_f_r <= 1'b0;
         div_r <= 4'h0;
         nib_en_r <= 1'b0;
      end else begin
         crs_s_r <= {crs_s_r[1:0], crs_pin};
         col_s_r <= {col_s_r[1:0], col_pin};
         if (crs_s_r[1] == crs_s_r[2])
            crs_f_r <= crs_s_r[2];
         if (col_s_r[1] == col_s_r[2])
            col_f_r <= col_s_r[2];
         if (div_r == `MIC_NIB_DIV - 4'h1) begin
            div_r <= 4'h0;
            nib_en_r <= 1'b1;
         end else begin
            div_r <= div_r + 4'h1;
            nib_en_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Gap, deferral and collision control
   wire full_dup = ctrl_r[`MIC_DUPLEX_BIT];
   wire skip_bo = ctrl_r[`MIC_SKIPBO_BIT];
   wire crs_h = crs_f_r & ~full_dup;
   wire col_h = col_f_r & ~full_dup;
   wire [7:0] b2b_thr, gap_thr;
   wire gap_met, in_window;
   reg [7:0] gap_cnt_r;
   reg [11:0] tx_nib_r;
   reg b2b_r_flag, bo_start_r;
   wire bo_done;

   // Field holds gap less the duplex offset
   assign b2b_thr = {1'b0, b2b_r[`MIC_B2B_F]} +
      (full_dup ? `MIC_FD_OFS : `MIC_HD_OFS);
   assign gap_thr = b2b_r_flag ? b2b_thr
      : {1'b0, nb2b_r[`MIC_NB2B_F]};
   assign gap_met = gap_cnt_r >= gap_thr;
   // Window measured in bytes from first preamble nibble
   assign in_window = tx_nib_r[11:1] < {5'h00, cwr_r[`MIC_SLOT_F]};

   mic_backoff mic_backoff_i (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .nib_en(nib_en_r),
      .start(bo_start_r),
      .attempt(att_r),
      .busy_r(),
      .done_r(bo_done)
   );

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         state_r <= ST_GAP;
         gap_cnt_r <= 8'h00;
         tx_nib_r <= 12'h000;
         b2b_r_flag <= 1'b0;
         att_r <= 4'h0;
         bo_start_r <= 1'b0;
         tx_go <= 1'b0;
         tx_abort <= 1'b0;
         tx_retry <= 1'b0;
         ev <= {`MIC_EV_W{1'b0}};
      end else begin
         bo_start_r <= 1'b0;
         tx_abort <= 1'b0;
         tx_retry <= 1'b0;
         ev <= {`MIC_EV_W{1'b0}};
         case (state_r)
            ST_GAP: begin
               if (crs_h && (gap_cnt_r < {1'b0, nb2b_r[`MIC_SLOT_WINDOW_LEN_F]})) begin
                  gap_cnt_r <= 8'h00;
                  b2b_r_flag <= 1'b0;
               end else if (gap_met)
                  state_r <= ST_READY;
               else if (nib_en_r)
                  gap_cnt_r <= gap_cnt_r + 8'h01;
            end
            ST_READY: begin
               if (crs_h && !pkt_pending) begin
                  state_r <= ST_GAP;
                  gap_cnt_r <= 8'h00;
                  b2b_r_flag <= 1'b0;
               end else if (pkt_pending) begin
                  // Carrier seen late is not deferred to
                  state_r <= ST_XMIT;
                  tx_go <= 1'b1;
                  tx_nib_r <= 12'h000;
               end
            end
            ST_XMIT: begin
               if (nib_en_r && tx_nib_r != 12'hfff)
                  tx_nib_r <= tx_nib_r + 12'h001;
               if (tx_done) begin
                  state_r <= ST_GAP;
                  tx_go <= 1'b0;
                  gap_cnt_r <= 8'h00;
                  b2b_r_flag <= 1'b1;
                  att_r <= 4'h0;
                  ev[`MIC_EV_DONE] <= 1'b1;
               end else if (col_h && in_window) begin
                  tx_go <= 1'b0;
                  gap_cnt_r <= 8'h00;
                  b2b_r_flag <= 1'b0;
                  ev[`MIC_EV_COL] <= 1'b1;
                  if (att_r == cwr_r[`MIC_RETRY_F]) begin
                     state_r <= ST_GAP;
                     att_r <= 4'h0;
                     tx_abort <= 1'b1;
                     ev[`MIC_EV_XCOL] <= 1'b1;
                  end else if (skip_bo) begin
                     state_r <= ST_GAP;
                     att_r <= att_r + 4'h1;
                     tx_retry <= 1'b1;
                  end else begin
                     state_r <= ST_BACK;
                     att_r <= att_r + 4'h1;
                     bo_start_r <= 1'b1;
                  end
               end else if (col_h && !in_window) begin
                  ev[`MIC_EV_LATE] <= 1'b1;
               end
            end
            ST_BACK: begin
               // Start pulse lands before busy rises
               if (bo_done) begin
                  state_r <= ST_GAP;
                  gap_cnt_r <= 8'h00;
                  tx_retry <= 1'b1;
               end
            end
            default: begin
               state_r <= ST_GAP;
               tx_go <= 1'b0;
            end
         endcase
      end
   end
endmodule

/* verilog/mic_defines.vh */
// Register map, field layout, reset values and timing counts
`ifndef MIC_DEFINES_VH
`define MIC_DEFINES_VH

`define MIC_ADDR_B2B 32'hff800408
`define MIC_ADDR_NB2B 32'hff80040c
`define MIC_ADDR_CWR 32'hff800410
`define MIC_ADDR_CTRL 32'hff800480
`define MIC_ADDR_STAT 32'hff800484
`define MIC_ADDR_MASK 32'hff800488
`define MIC_ADDR_STATE 32'hff80048c

`define MIC_B2B_F 6:0
`define MIC_SLOT_WINDOW_LEN_F 14:8
`define MIC_NB2B_F 6:0
`define MIC_SLOT_F 13:8
`define MIC_RETRY_F 3:0
`define MIC_DUPLEX_BIT 0
`define MIC_SKIPBO_BIT 12

`define MIC_B2B_RST 7'h12
`define MIC_SLOT_WINDOW_LEN_RST 7'h0c
`define MIC_NB2B_RST 7'h12
`define MIC_SLOT_RST 6'h37
`define MIC_RETRY_RST 4'hf

`define MIC_FD_OFS 8'h03
`define MIC_HD_OFS 8'h06

`define MIC_NIB_DIV 4'h2
`define MIC_SLOT_NIBS 7'h7f
`define MIC_BO_MAXEXP 4'ha

`define MIC_EV_XCOL 0
`define MIC_EV_LATE 1
`define MIC_EV_COL 2
`define MIC_EV_DONE 3
`define MIC_EV_W 4

`define MIC_RESP_OK 2'b00
`define MIC_RESP_ERR 2'b10

`endif

/* verilog/mic_backoff.v */
// Binary exponential backoff timer with a free-running random source
`timescale 1ns/100ps
`include "mic_defines.vh"
module mic_backoff (
   input wire ref_clk,
   input wire sys_rst,
   input wire nib_en,
   input wire start,
   input wire [3:0] attempt,
   output reg busy_r,
   output reg done_r
);
   reg [15:0] lfsr_r;
   reg [9:0] slots_r;
   reg [6:0] nib_r;
   wire [3:0] expo;
   wire [9:0] pick;

   assign expo = (attempt > `MIC_BO_MAXEXP) ? `MIC_BO_MAXEXP : attempt;
   // Random draw in 0 .. 2^expo-1 slots
   assign pick = lfsr_r[9:0] & ~(10'h3ff << expo);

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         lfsr_r <= 16'hace1;
         slots_r <= 10'h000;
         nib_r <= 7'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         lfsr_r <= {lfsr_r[14:0],
            lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
         done_r <= 1'b0;
         if (start) begin
            busy_r <= 1'b1;
            slots_r <= pick;
            nib_r <= `MIC_SLOT_NIBS;
         end else if (busy_r) begin
            if (slots_r == 10'h000) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end else if (nib_en) begin
               if (nib_r == 7'h00) begin
                  nib_r <= `MIC_SLOT_NIBS;
                  slots_r <= slots_r - 10'h001;
               end else begin
                  nib_r <= nib_r - 7'h01;
               end
            end
         end
      end
   end
endmodule

/* dv/mic_tx_timing_monitor.sv */
// Port-level checks on the transmit timing block
`timescale 1ns/100ps
module mic_tx_timing_monitor (
   input wire ref_clk,
   input wire sys_rst,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire tx_done,
   input wire tx_go,
   input wire tx_abort,
   input wire tx_retry,
   input wire irq
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////
   a_reset_quiet: assert property (disable iff (1'b0)
      sys_rst |=> !tx_go && !irq && !s_axi_bvalid && !s_axi_rvalid)
      else $error("output active after reset");
   // Smallest legal gap is three nibbles, six clocks
   a_done_gap_min: assert property (
      tx_done |=> !tx_go [*6])
      else $error("transmit restarted inside gap");
   a_abort_pulse: assert property (
      tx_abort |=> !tx_abort)
      else $error("abort longer than one cycle");
   a_retry_pulse: assert property (
      tx_retry |=> !tx_retry && !tx_go)
      else $error("retry not a single pulse");
   a_abort_no_retry: assert property (
      tx_abort |-> !tx_retry)
      else $error("abort and retry together");
   a_go_no_retry: assert property (
      tx_go |-> !tx_retry)
      else $error("retry while transmitting");
   a_ar_blocked: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   a_aw_single: assert property (
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("second write address taken at once");
endmodule

/* dv/mic_phy_model.sv */
// Far-side link model: frame end, carrier and collision
`timescale 1ns/100ps
module mic_phy_model #(
   parameter FRAME = 40
) (
   input wire ref_clk,
   input wire tx_go,
   input wire crs_req,
   input wire [7:0] col_at,
   output reg tx_done,
   output reg crs_pin,
   output reg col_pin
);
   integer n;
   initial begin
      n = 0;
      tx_done = 1'b0;
      crs_pin = 1'b0;
      col_pin = 1'b0;
   end
   // Collision held until the block stops sending, like a real jam
   always @(posedge ref_clk) begin
      crs_pin <= crs_req;
      tx_done <= tx_go && n == FRAME;
      col_pin <= tx_go && col_at != 8'h0 && n >= col_at;
      if (tx_go) begin
         n <= n + 1;
      end else begin
         n <= 0;
      end
   end
endmodule

/* dv/mic_tx_timing_bench.sv */
// Self-checking bench for the transmit timing block
`timescale 1ns/100ps
`include "mic_defines.vh"
module mic_tx_timing_bench;
   reg ref_clk = 1'b0;
   reg sys_rst = 1'b1;
   reg [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
   reg [31:0] s_axi_araddr = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   reg pkt_pending = 1'b0, crs_req = 1'b0, go_d = 1'b0;
   reg [7:0] col_at = 8'h0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire tx_done, crs_pin, col_pin, tx_go, tx_abort, tx_retry, irq;
   integer fail_count = 0, cmp_count = 0, cyc = 0, t_done = 0;
   integer t_go = 0, n_go = 0, n_done = 0, n_retry = 0, n_abort = 0;
   integer dt;
   mic_tx_timing mic_tx_timing_i (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .pkt_pending(pkt_pending),
      .tx_done(tx_done),
      .crs_pin(crs_pin),
      .col_pin(col_pin),
      .tx_go(tx_go),
      .tx_abort(tx_abort),
      .tx_retry(tx_retry),
      .irq(irq)
   );
   mic_phy_model mic_phy_model_i (
      .ref_clk(ref_clk),
      .tx_go(tx_go),
      .crs_req(crs_req),
      .col_at(col_at),
      .tx_done(tx_done),
      .crs_pin(crs_pin),
      .col_pin(col_pin)
   );
   initial forever #25 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////
   task results;
      begin
         if (fail_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
         end else begin
            $display("MISMATCHES SEEN");
         end
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("Error at %0t: got %h, want %h", $time, got, exp);
         end
      end
   endtask
   // Waits have no own limit; the cycle ceiling cuts a hang
   task wr(input [31:0] a, input [31:0] d, input [1:0] er);
      begin
         @(posedge ref_clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
         end while (!s_axi_bvalid);
         s_axi_bready <= 1'b0;
         chk({30'h0, s_axi_bresp}, {30'h0, er});
      end
   endtask
   task rd(input [31:0] a, input [31:0] exp, input [1:0] er);
      begin
         @(posedge ref_clk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (!s_axi_rvalid);
         s_axi_rready <= 1'b0;
         chk(s_axi_rdata, exp);
         chk({30'h0, s_axi_rresp}, {30'h0, er});
      end
   endtask
   // Two carrier bursts with 4+sep idle clocks between them; dt runs from the second
   task carrier(input integer sep);
      integer t, k, d;
      begin
         k = n_go;
         d = n_done;
         repeat (60) @(posedge ref_clk);
         crs_req <= 1'b1;
         repeat (4) @(posedge ref_clk);
         crs_req <= 1'b0;
         repeat (4) @(posedge ref_clk);
         pkt_pending <= 1'b1;
         repeat (sep) @(posedge ref_clk);
         t = cyc;
         crs_req <= 1'b1;
         repeat (4) @(posedge ref_clk);
         crs_req <= 1'b0;
         wait (n_go == k + 1);
         dt = t_go - t;
         wait (n_done == d + 1);
         @(posedge ref_clk);
         pkt_pending <= 1'b0;
      end
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      go_d <= tx_go;
      if (tx_done === 1'b1) begin
         t_done <= cyc;
         n_done <= n_done + 1;
      end
      if (tx_go === 1'b1 && go_d === 1'b0) begin
         t_go <= cyc;
         n_go <= n_go + 1;
      end
      if (tx_retry === 1'b1) n_retry <= n_retry + 1;
      if (tx_abort === 1'b1) n_abort <= n_abort + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         results;
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd(`MIC_ADDR_B2B, 32'h12, 2'b00);
      rd(`MIC_ADDR_NB2B, 32'hc12, 2'b00);
      rd(`MIC_ADDR_CWR, 32'h370f, 2'b00);
      rd(`MIC_ADDR_CTRL, 32'h0, 2'b00);
      rd(32'hff800414, 32'h0, 2'b10);
      wr(32'hff800414, 32'h1, 2'b10);
      wr(`MIC_ADDR_NB2B, 32'hffffffff, 2'b00);
      rd(`MIC_ADDR_NB2B, 32'h7f7f, 2'b00);
      wr(`MIC_ADDR_CWR, 32'hffffffff, 2'b00);
      rd(`MIC_ADDR_CWR, 32'h3f0f, 2'b00);
      // Gap after a frame: field plus six, then plus three
      wr(`MIC_ADDR_B2B, 32'h4, 2'b00);
      @(posedge ref_clk);
      pkt_pending <= 1'b1;
      wait (n_go == 2);
      chk(t_go - t_done >= 20 && t_go - t_done <= 26, 1);
      wr(`MIC_ADDR_CTRL, 32'h1, 2'b00);
      wait (n_go == 3);
      chk(t_go - t_done >= 14 && t_go - t_done <= 20, 1);
      wr(`MIC_ADDR_CTRL, 32'h0, 2'b00);
      wait (n_done == 3);
      @(posedge ref_clk);
      pkt_pending <= 1'b0;
      // Window of ten nibbles inside a gap of twenty
      wr(`MIC_ADDR_NB2B, 32'h0a14, 2'b00);
      carrier(0);
      chk(dt >= 40, 1);
      carrier(24);
      chk(dt <= 24, 1);
      // Retry limit two with immediate retransmission
      wr(`MIC_ADDR_STAT, 32'hf, 2'b00);
      wr(`MIC_ADDR_CWR, 32'h3702, 2'b00);
      wr(`MIC_ADDR_CTRL, 32'h1000, 2'b00);
      wr(`MIC_ADDR_MASK, 32'h1, 2'b00);
      @(posedge ref_clk);
      col_at <= 8'h4;
      pkt_pending <= 1'b1;
      wait (n_abort == 1);
      @(posedge ref_clk);
      pkt_pending <= 1'b0;
      chk(n_retry, 2);
      rd(`MIC_ADDR_STAT, 32'h5, 2'b00);
      chk({31'h0, irq}, 1);
      wr(`MIC_ADDR_STAT, 32'h1, 2'b00);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq}, 0);
      // Slot of two bytes, collision long after it
      wr(`MIC_ADDR_STAT, 32'hf, 2'b00);
      wr(`MIC_ADDR_CWR, 32'h0202, 2'b00);
      @(posedge ref_clk);
      col_at <= 8'd20;
      pkt_pending <= 1'b1;
      wait (n_done == 6);
      @(posedge ref_clk);
      pkt_pending <= 1'b0;
      chk(n_retry, 2);
      rd(`MIC_ADDR_STAT, 32'ha, 2'b00);
      // Retry limit one with random backoff before the retry
      wr(`MIC_ADDR_STAT, 32'hf, 2'b00);
      wr(`MIC_ADDR_CWR, 32'h3701, 2'b00);
      wr(`MIC_ADDR_CTRL, 32'h0, 2'b00);
      @(posedge ref_clk);
      col_at <= 8'h4;
      pkt_pending <= 1'b1;
      wait (n_abort == 2);
      @(posedge ref_clk);
      pkt_pending <= 1'b0;
      chk(n_retry, 3);
      rd(`MIC_ADDR_STAT, 32'h5, 2'b00);
      // Attempts cleared, idle gap done, waiting for a packet
      repeat (60) @(posedge ref_clk);
      rd(`MIC_ADDR_STATE, 32'h2, 2'b00);
      results;
   end
endmodule
bind mic_tx_timing mic_tx_timing_monitor mic_tx_timing_monitor_i (
   .ref_clk(ref_clk),
   .sys_rst(sys_rst),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid),
   .tx_done(tx_done),
   .tx_go(tx_go),
   .tx_abort(tx_abort),
   .tx_retry(tx_retry),
   .irq(irq)
);
